// ### pkg/dss_cfg.svh
`ifndef DSS_CFG_SVH
`define DSS_CFG_SVH

`define DSS_CW_ADDR        16'h6040
`define DSS_SW_ADDR        16'h6041
`define DSS_MODE_ADDR      16'h6060
`define DSS_MODE_DISP_ADDR 16'h6061

`define DSS_CW_SO 0
`define DSS_CW_EV 1
`define DSS_CW_QS 2
`define DSS_CW_EO 3
`define DSS_CW_FR 7

`define DSS_SW_RTSO  0
`define DSS_SW_SON   1
`define DSS_SW_OE    2
`define DSS_SW_FLT   3
`define DSS_SW_VE    4
`define DSS_SW_QS    5
`define DSS_SW_SOD   6
`define DSS_SW_WARN  7
`define DSS_SW_VS0   8
`define DSS_SW_REM   9
`define DSS_SW_TGT   10
`define DSS_SW_LIM   11
`define DSS_SW_OMS0  12
`define DSS_SW_OMS1  13
`define DSS_SW_VS1   14
`define DSS_SW_VS2   15

`define DSS_MODE_OFF  8'h00
`define DSS_MODE_PROF_POS  8'h01
`define DSS_MODE_PROF_VEL  8'h03
`define DSS_MODE_HOMING    8'h06
`define DSS_MODE_SYNC_POS  8'h08
`define DSS_MODE_SYNC_VEL  8'h09
`define DSS_MODE_RST  8'h00

`define DSS_ALM_NONE  8'h00
`define DSS_ALM_NET   8'h81
`define DSS_ALM_POWER 8'h23

`define DSS_SW_RST    16'h0000

`endif

// ### pkg/dss_pkg.sv
`default_nettype none
package dss_pkg;
  typedef enum logic [3:0] {
    st_start,
    st_not_ready,
    st_sw_on_disabled,
    st_ready,
    st_switched_on,
    st_op_enabled,
    st_quick_stop,
    st_fault_react,
    st_fault
  } dss_state_t;
endpackage
`default_nettype wire

// ### pkg/dss_status_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dss_status_if;
  dss_pkg::dss_state_t state;
  logic                main_power;
  logic [7:0]          mode_eff;
  logic                warning;
  logic                remote;
  logic                target_reached;
  logic                limit_active;
  logic [1:0]          oms_bits;
  logic [2:0]          vendor_bits;
  logic [15:0]         word;

  modport enc (
    input  state, main_power, mode_eff, warning, remote,
    input  target_reached, limit_active, oms_bits, vendor_bits,
    output word
  );
  modport top (
    output state, main_power, mode_eff, warning, remote,
    output target_reached, limit_active, oms_bits, vendor_bits,
    input  word
  );
endinterface
`default_nettype wire

// ### hw/dss_status_enc.sv
`include "dss_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dss_status_enc (
  dss_status_if.enc st  // state in, status word out
);
  logic [6:0] flags;
  logic       mode_on;

  assign mode_on = (st.mode_eff != `DSS_MODE_OFF);

  // state encodings
  // bit order: sod, qs, ve(unused here), flt, oe, son, rtso
  always_comb begin
    flags = 7'h00;
    unique case (st.state)
      dss_pkg::st_start:          flags = 7'h00;
      dss_pkg::st_not_ready:      flags = 7'h00;
      dss_pkg::st_fault:          flags = 7'h28;
      dss_pkg::st_fault_react:    flags = 7'h2f;
      dss_pkg::st_sw_on_disabled: flags = 7'h60;
      dss_pkg::st_ready:          flags = 7'h21;
      dss_pkg::st_switched_on:    flags = 7'h23;
      dss_pkg::st_op_enabled:     flags = 7'h27;
      dss_pkg::st_quick_stop:     flags = 7'h07;
    endcase
  end

  always_comb begin
    st.word                 = `DSS_SW_RST;
    st.word[`DSS_SW_RTSO]   = flags[`DSS_SW_RTSO];
    st.word[`DSS_SW_SON]    = flags[`DSS_SW_SON];
    st.word[`DSS_SW_OE]     = flags[`DSS_SW_OE];
    st.word[`DSS_SW_FLT]    = flags[`DSS_SW_FLT];
    st.word[`DSS_SW_VE]     = st.main_power;
    st.word[`DSS_SW_QS]     = flags[`DSS_SW_QS];
    st.word[`DSS_SW_SOD]    = flags[`DSS_SW_SOD];
    st.word[`DSS_SW_WARN]   = st.warning;
    st.word[`DSS_SW_VS0]    = st.vendor_bits[0];
    st.word[`DSS_SW_REM]    = st.remote;
    st.word[`DSS_SW_TGT]    = st.target_reached & mode_on;
    st.word[`DSS_SW_LIM]    = st.limit_active & mode_on;
    st.word[`DSS_SW_OMS0]   = st.oms_bits[0] & mode_on;
    st.word[`DSS_SW_OMS1]   = st.oms_bits[1] & mode_on;
    st.word[`DSS_SW_VS1]    = st.vendor_bits[1];
    st.word[`DSS_SW_VS2]    = st.vendor_bits[2];
  end
endmodule
`default_nettype wire

// ### hw/dss_top.sv
`include "dss_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dss_top (
  input  wire logic        ref_clk,          // 125 MHz clock
  input  wire logic        resetn,           // sync reset, active low
  input  wire logic        ce,               // clock enable
  input  wire logic [15:0] ctrl_word,        // control word object
  input  wire logic        mode_wr,          // mode selector write strobe
  input  wire logic [7:0]  mode_wdata,       // mode selector write value
  input  wire logic        net_operational,  // network state machine op
  input  wire logic        main_power_on,    // main power supplied
  input  wire logic        power_removal,    // power removal status
  input  wire logic        free_run_in,      // free-run input
  input  wire logic        motion_active,    // motor is moving
  input  wire logic        init_done,        // initialisation complete
  input  wire logic        warning_in,       // warning flag
  input  wire logic        remote_in,        // remote flag
  input  wire logic        target_reached_in,// target reached
  input  wire logic        limit_active_in,  // internal limit active
  input  wire logic [1:0]  oms_bits_in,      // mode specific bits
  input  wire logic [2:0]  vendor_bits_in,   // vendor specific bits
  output logic [15:0]      status_word_q,    // status word object
  output logic [7:0]       mode_select_q,    // mode selector readback
  output logic [7:0]       mode_report_q,    // mode in effect
  output logic [7:0]       alarm_code_q,     // latched alarm code
  output logic             motor_excite_q    // motor excitation
);
  dss_pkg::dss_state_t state_q;
  dss_pkg::dss_state_t state_d;
  logic [7:0]          alarm_d;
  logic                fault_rst_q;
  dss_status_if        st_if ();

  // ---------------------------------------------------------------
  // control word decode
  // ---------------------------------------------------------------
  wire [3:0] cw_low      = {ctrl_word[`DSS_CW_EO], ctrl_word[`DSS_CW_QS],
                            ctrl_word[`DSS_CW_EV], ctrl_word[`DSS_CW_SO]};
  wire       cmd_shut    = (cw_low[2:0] == 3'h6);
  wire       cmd_son     = (cw_low == 4'h7);
  wire       cmd_enable  = (cw_low == 4'hf);
  wire       cmd_dis_v   = ~cw_low[1];
  wire       cmd_qstop   = (cw_low[2:1] == 2'h1);
  wire       fault_rise  = ctrl_word[`DSS_CW_FR] & ~fault_rst_q;
  wire       net_lost    = ~net_operational;
  wire       pwr_lost    = ~main_power_on;
  wire       drop_excite = power_removal | free_run_in;
  wire       any_event   = net_lost | pwr_lost | drop_excite;
  wire       son_ok      = net_operational & main_power_on & ~drop_excite;
  wire       mode_legal  = (mode_wdata == `DSS_MODE_OFF)      |
                           (mode_wdata == `DSS_MODE_PROF_POS) |
                           (mode_wdata == `DSS_MODE_PROF_VEL) |
                           (mode_wdata == `DSS_MODE_HOMING)   |
                           (mode_wdata == `DSS_MODE_SYNC_POS) |
                           (mode_wdata == `DSS_MODE_SYNC_VEL);
  wire [7:0] mode_report_d = motion_active ? mode_report_q : mode_select_q;
  wire       excite_d    = (state_d == dss_pkg::st_op_enabled) |
                           (state_d == dss_pkg::st_quick_stop) |
                           (state_d == dss_pkg::st_fault_react);

  // ---------------------------------------------------------------
  // drive state machine, events ahead of commands except in ready and switched on, where disable voltage and quick stop come first
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    alarm_d = alarm_code_q;
    unique case (state_q)
      dss_pkg::st_start:     state_d = dss_pkg::st_not_ready;
      dss_pkg::st_not_ready: if (init_done) begin
        state_d = dss_pkg::st_sw_on_disabled;
      end
      dss_pkg::st_sw_on_disabled: if (cmd_shut) begin
        state_d = dss_pkg::st_ready;
      end
      dss_pkg::st_ready: begin
        if (cmd_dis_v || cmd_qstop) begin
          state_d = dss_pkg::st_sw_on_disabled;
        end else if ((cmd_son || cmd_enable) && son_ok) begin
          state_d = dss_pkg::st_switched_on;
        end
      end
      dss_pkg::st_switched_on: begin
        if (cmd_dis_v || cmd_qstop) begin
          state_d = dss_pkg::st_sw_on_disabled;
        end else if (any_event || cmd_shut) begin
          state_d = dss_pkg::st_ready;
        end else if (cmd_enable) begin
          state_d = dss_pkg::st_op_enabled;
        end
      end
      dss_pkg::st_op_enabled: begin
        if (motion_active && net_lost) begin
          state_d = dss_pkg::st_fault_react;
          alarm_d = `DSS_ALM_NET;
        end else if (motion_active && pwr_lost) begin
          state_d = dss_pkg::st_fault_react;
          alarm_d = `DSS_ALM_POWER;
        end else if (any_event) begin
          state_d = dss_pkg::st_ready;
        end else if (cmd_dis_v) begin
          state_d = dss_pkg::st_sw_on_disabled;
        end else if (cmd_qstop) begin
          state_d = dss_pkg::st_quick_stop;
        end else if (cmd_shut) begin
          state_d = dss_pkg::st_ready;
        end else if (cmd_son) begin
          state_d = dss_pkg::st_switched_on;
        end
      end
      dss_pkg::st_quick_stop: begin
        if (motion_active && net_lost) begin
          state_d = dss_pkg::st_fault_react;
          alarm_d = `DSS_ALM_NET;
        end else if (motion_active && pwr_lost) begin
          state_d = dss_pkg::st_fault_react;
          alarm_d = `DSS_ALM_POWER;
        end else if (any_event || cmd_dis_v || !motion_active) begin
          state_d = dss_pkg::st_sw_on_disabled;
        end else if (cmd_enable) begin
          state_d = dss_pkg::st_op_enabled;
        end
      end
      dss_pkg::st_fault_react: if (!motion_active) begin
        state_d = dss_pkg::st_fault;
      end
      dss_pkg::st_fault: if (fault_rise) begin
        state_d = dss_pkg::st_sw_on_disabled;
        alarm_d = `DSS_ALM_NONE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // status encoder link
  // ---------------------------------------------------------------
  // encode next state so bits move with it
  assign st_if.state          = state_d;
  assign st_if.main_power     = main_power_on;
  // gate on the mode that the report will show
  assign st_if.mode_eff       = mode_report_d;
  assign st_if.warning        = warning_in;
  assign st_if.remote         = remote_in;
  assign st_if.target_reached = target_reached_in;
  assign st_if.limit_active   = limit_active_in;
  assign st_if.oms_bits       = oms_bits_in;
  assign st_if.vendor_bits    = vendor_bits_in;

  dss_status_enc u_enc (
    .st (st_if.enc)
  );

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q        <= dss_pkg::st_start;
      alarm_code_q   <= `DSS_ALM_NONE;
      fault_rst_q    <= 1'b0;
      status_word_q  <= `DSS_SW_RST;
      motor_excite_q <= 1'b0;
    end else if (ce) begin
      state_q        <= state_d;
      alarm_code_q   <= alarm_d;
      fault_rst_q    <= ctrl_word[`DSS_CW_FR];
      status_word_q  <= st_if.word;
      motor_excite_q <= excite_d;
    end
  end

  // mode select and mode in effect
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_select_q <= `DSS_MODE_RST;
      mode_report_q <= `DSS_MODE_RST;
    end else if (ce) begin
      if (mode_wr && mode_legal) begin
        mode_select_q <= mode_wdata;
      end
      mode_report_q <= mode_report_d;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_net_alarm;
    ce && motion_active && net_lost &&
    (state_q == dss_pkg::st_op_enabled || state_q == dss_pkg::st_quick_stop)
    |=> state_q == dss_pkg::st_fault_react && alarm_code_q == `DSS_ALM_NET
        && motor_excite_q;
  endproperty
  a_net_alarm: assert property (p_net_alarm)
    else $error("network loss did not raise alarm 81h");

  property p_power_alarm;
    ce && motion_active && net_operational && pwr_lost &&
    (state_q == dss_pkg::st_op_enabled || state_q == dss_pkg::st_quick_stop)
    |=> state_q == dss_pkg::st_fault_react && alarm_code_q == `DSS_ALM_POWER;
  endproperty
  a_power_alarm: assert property (p_power_alarm)
    else $error("power loss did not raise alarm 23h");

  property p_oe_drop;
    ce && state_q == dss_pkg::st_op_enabled && net_operational &&
    main_power_on && drop_excite
    |=> state_q == dss_pkg::st_ready && !motor_excite_q;
  endproperty
  a_oe_drop: assert property (p_oe_drop)
    else $error("free-run or removal did not reach ready");

  property p_qs_stop;
    ce && state_q == dss_pkg::st_quick_stop && !motion_active && any_event
    |=> state_q == dss_pkg::st_sw_on_disabled && !motor_excite_q;
  endproperty
  a_qs_stop: assert property (p_qs_stop)
    else $error("quick stop event did not reach switch on disabled");

  property p_fault_bits;
    state_q == dss_pkg::st_fault |-> (status_word_q[6:0] & 7'h6f) == 7'h28;
  endproperty
  a_fault_bits: assert property (p_fault_bits)
    else $error("fault encoding wrong");

  property p_oe_bits;
    state_q == dss_pkg::st_op_enabled |->
      (status_word_q[6:0] & 7'h6f) == 7'h27;
  endproperty
  a_oe_bits: assert property (p_oe_bits)
    else $error("operation enabled encoding wrong");

  property p_volt;
    ce |=> status_word_q[`DSS_SW_VE] == $past(main_power_on);
  endproperty
  a_volt: assert property (p_volt)
    else $error("voltage enabled does not follow main power");

  property p_mode_hold;
    ce && motion_active |=> mode_report_q == $past(mode_report_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed during motion");

  property p_mode_take;
    ce && !motion_active |=> mode_report_q == $past(mode_select_q);
  endproperty
  a_mode_take: assert property (p_mode_take)
    else $error("mode report did not take selected mode");

  property p_startup;
    ce && state_q == dss_pkg::st_not_ready && init_done
    |=> state_q == dss_pkg::st_sw_on_disabled
        && status_word_q[`DSS_SW_SOD];
  endproperty
  a_startup: assert property (p_startup)
    else $error("init done did not reach switch on disabled");

  c_fault: cover property (state_q == dss_pkg::st_fault_react
                           ##[1:20] state_q == dss_pkg::st_fault);
  c_oe: cover property (state_q == dss_pkg::st_op_enabled);
  c_mode_wait: cover property (motion_active && mode_select_q != mode_report_q
                               ##[1:20] mode_select_q == mode_report_q);
endmodule
`default_nettype wire

// ### testbench/dss_master.sv
`timescale 1ns/1ps
`default_nettype none
module dss_master (
  input  wire logic        ref_clk,    // drive clock
  output logic      [15:0] ctrl_word,  // control word object
  output logic             mode_wr,    // mode selector write strobe
  output logic      [7:0]  mode_wdata  // mode selector value
);
  initial begin
    ctrl_word = 16'h0000;
    mode_wr = 1'b0;
    mode_wdata = 8'h00;
  end

  // command in bits 0..3 and 7
  task automatic cmd(input logic [15:0] cw);
    @(negedge ref_clk);
    ctrl_word = cw | (16'($urandom) & 16'hff70);
  endtask

  // mode written as a one cycle strobe
  task automatic set_mode(input logic [7:0] v);
    @(negedge ref_clk);
    mode_wr = 1'b1;
    mode_wdata = v;
    @(negedge ref_clk);
    mode_wr = 1'b0;
    mode_wdata = ~v;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_drive_state_status_and_mode_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_drive_state_status_and_mode_select;
  logic        ref_clk = 1'b0;
  logic        resetn, ce, net, pwr, prem, free, mot, init;
  logic        warn, remi, tgt, lim, rnd_en, run = 1'b0;
  logic [1:0]  oms;
  logic [2:0]  vend;
  wire logic [15:0] cw, sw;
  wire logic [7:0]  md, msel, mrep, alm_q;
  wire logic        mw, exc_q;
  int          st = 0, nx, errors = 0, num_checks = 0, cyc = 0, rcnt = 0;
  logic [7:0]  sel = 8'h00, rep = 8'h00, alm = 8'h00;
  logic [31:0] r;
  logic        p7 = 1'b0, ev, dv, qsc, shut, swon, en;
  logic [15:0] exp_sw = 16'h0000;
  logic [6:0]  lv;
  logic [6:0]  lut [9] = '{7'h00, 7'h00, 7'h60, 7'h21, 7'h23, 7'h27,
                           7'h07, 7'h2f, 7'h28};
  logic [7:0]  modes [8] = '{8'h01, 8'h03, 8'h06, 8'h08, 8'h09, 8'h05,
                             8'h00, 8'h09};

  dss_master u_m (.ref_clk(ref_clk), .ctrl_word(cw), .mode_wr(mw),
                  .mode_wdata(md));

  dss_top dut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .ctrl_word(cw),
    .mode_wr(mw), .mode_wdata(md), .net_operational(net),
    .main_power_on(pwr), .power_removal(prem), .free_run_in(free),
    .motion_active(mot), .init_done(init), .warning_in(warn),
    .remote_in(remi), .target_reached_in(tgt), .limit_active_in(lim),
    .oms_bits_in(oms), .vendor_bits_in(vend), .status_word_q(sw),
    .mode_select_q(msel), .mode_report_q(mrep), .alarm_code_q(alm_q),
    .motor_excite_q(exc_q));

  always #4 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // reference model, one step per enabled edge
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!resetn) begin
      st = 0;
      sel = 8'h00;
      rep = 8'h00;
      alm = 8'h00;
      p7 = 1'b0;
      exp_sw = 16'h0000;
    end else if (ce) begin
      ev = !net || !pwr || prem || free;
      dv = !cw[1];
      qsc = cw[2:1] == 2'b01;
      shut = cw[2:0] == 3'b110;
      swon = cw[3:0] == 4'b0111;
      en = cw[3:0] == 4'b1111;
      nx = st;
      case (st)
        0: nx = 1;
        1: if (init) nx = 2;
        2: if (shut) nx = 3;
        3: if (dv || qsc) nx = 2;
           else if ((swon || en) && !ev) nx = 4;
        4: if (dv || qsc) nx = 2;
           else if (ev || shut) nx = 3;
           else if (en) nx = 5;
        5: if (mot && (!net || !pwr)) nx = 7;
           else if (ev || shut) nx = 3;
           else if (dv) nx = 2;
           else if (qsc) nx = 6;
           else if (swon) nx = 4;
        6: if (mot && (!net || !pwr)) nx = 7;
           else if (!mot || prem || free || dv) nx = 2;
           else if (en) nx = 5;
        7: if (!mot) nx = 8;
        8: if (cw[7] && !p7) nx = 2;
        default: nx = st;
      endcase
      if (nx == 7 && st != 7) alm = !net ? 8'h81 : 8'h23;
      if (nx == 2 && st == 8) alm = 8'h00;
      if (!mot) rep = sel;
      if (mw && md inside {8'h00, 8'h01, 8'h03, 8'h06, 8'h08, 8'h09})
        sel = md;
      p7 = cw[7];
      st = nx;
      lv = lut[st];
      lv[4] = pwr;
      exp_sw = {vend[2:1], rep != 0 ? {oms, lim, tgt} : 4'h0, remi,
                vend[0], warn, lv};
    end
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] ex);
    num_checks++;
    if (seen !== ex) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial @(posedge ref_clk) run = 1'b1;

  always @(negedge ref_clk) begin
    if (run) begin
      check("status", sw, exp_sw);
      check("mode_select", {8'h00, msel}, {8'h00, sel});
      check("mode_report", {8'h00, mrep}, {8'h00, rep});
      check("alarm", {8'h00, alm_q}, {8'h00, alm});
      check("excite", {15'h0, exc_q}, {15'h0, st inside {5, 6, 7}});
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done();
    end
  end

  always @(negedge ref_clk) begin
    rcnt++;
    if (rnd_en && rcnt % 16 == 0)
      {warn, remi, tgt, lim, oms, vend} = 9'($urandom);
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic go_oe();
    u_m.cmd(16'h0006);
    tick(1);
    u_m.cmd(16'h000f);
    tick(3);
  endtask

  initial begin
    void'($urandom(32'hea95d060));
    {resetn, ce, net, pwr, prem, free, mot, init} = 8'b0111_0000;
    {warn, remi, tgt, lim, oms, vend, rnd_en} = 10'h000;
    tick(6);
    resetn = 1'b1;
    tick(3);
    init = 1'b1;
    tick(3);
    rnd_en = 1'b1;
    foreach (modes[i]) begin
      u_m.set_mode(modes[i]);
      tick(1);
    end
    u_m.cmd(16'h0006);
    tick(1);
    free = 1'b1;
    u_m.cmd(16'h000f);
    tick(3);
    free = 1'b0;
    tick(4);
    mot = 1'b1;
    u_m.set_mode(8'h03);
    tick(3);
    mot = 1'b0;
    tick(3);
    mot = 1'b1;
    free = 1'b1;
    tick(2);
    free = 1'b0;
    tick(4);
    prem = 1'b1;
    tick(2);
    prem = 1'b0;
    mot = 1'b0;
    tick(4);
    for (int i = 0; i < 3; i++) begin
      go_oe();
      mot = 1'b1;
      tick(1);
      net = (i == 1);
      pwr = (i == 0);
      tick(2);
      mot = 1'b0;
      tick(2);
      {net, pwr} = 2'b11;
      u_m.cmd(16'h0080);
      tick(2);
    end
    for (int j = 0; j < 3; j++) begin
      go_oe();
      mot = 1'b1;
      u_m.cmd(16'h0002);
      tick(2);
      free = (j == 0);
      net = (j != 1);
      mot = (j != 2);
      tick(2);
      mot = 1'b0;
      tick(2);
      {free, net} = 2'b01;
      u_m.cmd(16'h0080);
      tick(2);
    end
    // random walk over events, commands, mode writes and clock enable
    repeat (300) begin
      r = $urandom;
      net = |r[2:0];
      pwr = |r[5:3];
      prem = &r[8:6];
      free = &r[11:9];
      mot = r[12];
      ce = r[13] | r[14];
      if (r[20] && r[21])
        u_m.set_mode({4'h0, r[27:24]});
      else
        u_m.cmd({8'h00, r[15], 3'h0, r[19:16]});
    end
    {net, pwr, prem, free, mot, ce} = 6'b110001;
    u_m.cmd(16'h0000);
    u_m.cmd(16'h0080);
    tick(2);
    go_oe();
    rnd_en = 1'b0;
    ce = 1'b0;
    u_m.cmd(16'h0006);
    u_m.set_mode(8'h01);
    tick(4);
    ce = 1'b1;
    tick(3);
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(5);
    test_done();
  end
endmodule
`default_nettype wire
